// ==== resr_host.sv ====
// Host model that issues register requests to the bank
`timescale 1ns/1ps
`default_nettype none
module resr_host (
  input wire logic clk_sys_in,
  output resr_pkg::resr_req_t req_out,
  output logic unlock_ok_out
);
  import resr_pkg::*;
  // ==========================================================
  // Requests launch 1 ns after the edge and hold through the taking edge
  initial begin
    req_out = '0;
    unlock_ok_out = 1'b0;
  end
  task automatic op(input logic w, input logic r, input logic [7:0] a,
                    input logic [7:0] d, input logic u);
    @(posedge clk_sys_in);
    #1;
    req_out = '{wr: w, rd: r, addr: a, wdata: d};
    unlock_ok_out = u;
  endtask : op
  // Released bus shows inverted values so stale data cannot pass
  task automatic idle();
    @(posedge clk_sys_in);
    #1;
    req_out = '{wr: 1'b0, rd: 1'b0, addr: ~req_out.addr,
                wdata: ~req_out.wdata};
    unlock_ok_out = 1'b0;
  endtask : idle
endmodule : resr_host
`default_nettype wire

// ==== resr_pkg.sv ====
// Package for the rail enable and sequencer register bank
package resr_pkg;
  // ==========================================================
  // Register offsets and reset values
  localparam logic [7:0] RESR_OFS_ENABLE = 8'h16;
  localparam logic [7:0] RESR_OFS_UVLO = 8'h18;
  localparam logic [7:0] RESR_OFS_SEQ_STROBE_MAP_ONE = 8'h19;
  localparam logic [7:0] RESR_OFS_SEQ_STROBE_MAP_TWO = 8'h1A;
  localparam logic [7:0] RESR_RST_ENABLE = 8'h00;
  localparam logic [7:0] RESR_RST_UVLO = 8'h03;
  // Reset values of the map registers are variant specific; plain defaults
  localparam logic [7:0] RESR_RST_SEQ_STROBE_MAP_ONE = 8'h00;
  localparam logic [7:0] RESR_RST_SEQ_STROBE_MAP_TWO = 8'h00;
  // ==========================================================
  // Writable bit masks
  localparam logic [7:0] RESR_WM_ENABLE = 8'h7F;
  localparam logic [7:0] RESR_WM_UVLO = 8'h07;
  localparam logic [7:0] RESR_WM_SEQ_STROBE_MAP_ONE = 8'h77;
  localparam logic [7:0] RESR_WM_SEQ_STROBE_MAP_TWO = 8'h7F;
  // ==========================================================
  // Field positions
  localparam int RESR_B_SW1 = 6;
  localparam int RESR_B_SW2 = 5;
  localparam int RESR_B_BK1 = 4;
  localparam int RESR_B_BK2 = 3;
  localparam int RESR_B_BK3 = 2;
  localparam int RESR_B_LR1 = 1;
  localparam int RESR_B_LR2 = 0;
  localparam int RESR_NUM_RAILS = 7;
  // ==========================================================
  // Four-bit slot codes
  localparam logic [3:0] RESR_L_NOSEQ_A = 4'h8;
  localparam logic [3:0] RESR_L_NOSEQ_B = 4'h9;
  localparam logic [3:0] RESR_L_RSV_LO = 4'hA;
  localparam logic [3:0] RESR_L_RSV_HI = 4'hD;
  localparam logic [3:0] RESR_L_S14 = 4'hE;
  localparam logic [3:0] RESR_L_S15 = 4'hF;

  typedef enum logic [1:0] {
    RESR_UV_2V73 = 2'b00,
    RESR_UV_2V89 = 2'b01,
    RESR_UV_3V18 = 2'b10,
    RESR_UV_3V30 = 2'b11
  } resr_uvlo_t;

  // Register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } resr_req_t;

  // Decoded strobe slot of one rail (0 = not sequenced)
  typedef struct packed {
    logic [3:0] strobe;
    logic with_sys;
    logic reserved;
  } resr_slot_t;
endpackage : resr_pkg

// ==== resr_regs.sv ====
// Rail enable, undervoltage and sequencer strobe map registers
// ==========================================================
// Notes on behaviour
// [RQ1] Enable register at 0x16 resets to 0x00, bit 7 reads zero, bits 6..0 R/W.
// [RQ2] Bit 6 turns on switch one only while the power enable pin is high.
// [RQ3] Bit 5 turns on switch two only while the power enable pin is high.
// [RQ4] Bits 4, 3, 2 turn on bucks one to three only while the pin is high.
// [RQ5] Bits 1 and 0 turn linear regulators one and two on or off directly.
// [RQ6] These registers accept a write only while the unlock input is set.
// [RQ7] Undervoltage register at 0x18 resets to 0x03, bits 7..3 read 0, bit 2 R/W.
// [RQ8] Bits 1..0 pick the lockout level 2.73, 2.89, 3.18 or 3.3 V.
// [RQ9] First map at 0x19 holds buck one slot in 6..4 and buck two in 2..0.
// [RQ10] Slot code zero leaves a rail unsequenced, code n sequences at strobe n.
// [RQ11] Second map at 0x1A holds buck three slot in 6..4, linreg one in 3..0.
// [RQ12] Linreg one codes 8 and 9 are unsequenced, A..D reserved, E strobe 14, F 15 with system.
// [RQ13] Three-bit codes 6 and 7 map to strobes 6 and 7.
`timescale 1ns/1ps
`default_nettype none
module resr_regs (
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire resr_pkg::resr_req_t req_in,
  input wire logic unlock_ok_in,
  input wire logic power_enable_pin_in,
  output logic [7:0] rdata_out,
  output logic rd_err_out,
  output logic wr_refused_out,
  output logic switch_one_on_out,
  output logic switch_two_on_out,
  output logic buck_one_on_out,
  output logic buck_two_on_out,
  output logic buck_three_on_out,
  output logic linreg_one_on_out,
  output logic linreg_two_on_out,
  output resr_pkg::resr_uvlo_t lockout_threshold_out,
  output resr_pkg::resr_slot_t buck_one_slot_out,
  output resr_pkg::resr_slot_t buck_two_slot_out,
  output resr_pkg::resr_slot_t buck_three_slot_out,
  output resr_pkg::resr_slot_t linreg_one_slot_out
);
  import resr_pkg::*;

  // ==========================================================
  // Slot decoding
  function automatic resr_slot_t dec3(input logic [2:0] code);
    resr_slot_t s;
    s = '0;
    s.strobe = {1'b0, code}; // [RQ10] [RQ13]
    return s;
  endfunction : dec3

  function automatic resr_slot_t dec4(input logic [3:0] code);
    resr_slot_t s;
    s = '0;
    if (code == RESR_L_NOSEQ_A || code == RESR_L_NOSEQ_B) begin
      s.strobe = 4'h0; // [RQ12]
    end else if (code >= RESR_L_RSV_LO && code <= RESR_L_RSV_HI) begin
      s.reserved = 1'b1; // [RQ12]
    end else if (code == RESR_L_S15) begin
      s.strobe = code;
      s.with_sys = 1'b1; // [RQ12]
    end else begin
      s.strobe = code; // [RQ10] [RQ12]
    end
    return s;
  endfunction : dec4

  // ==========================================================
  // Address decode
  logic [7:0] enable_r;
  logic [7:0] uvlo_r;
  logic [7:0] seq_strobe_map_one_r;
  logic [7:0] seq_strobe_map_two_r;
  logic [7:0] rdata_r;
  logic rd_err_r;
  logic refused_r;
  wire hit_en = (req_in.addr == RESR_OFS_ENABLE);
  wire hit_uv = (req_in.addr == RESR_OFS_UVLO);
  wire hit_s1 = (req_in.addr == RESR_OFS_SEQ_STROBE_MAP_ONE);
  wire hit_s2 = (req_in.addr == RESR_OFS_SEQ_STROBE_MAP_TWO);
  wire hit_any = hit_en | hit_uv | hit_s1 | hit_s2;
  // Locked writes are dropped so a stray bus write cannot kill a rail
  wire wr_ok = req_in.wr & unlock_ok_in; // [RQ6]
  logic [7:0] rd_mux;
  always_comb begin
    if (hit_en) begin
      rd_mux = enable_r & RESR_WM_ENABLE; // [RQ1]
    end else if (hit_uv) begin
      rd_mux = uvlo_r & RESR_WM_UVLO; // [RQ7]
    end else if (hit_s1) begin
      rd_mux = seq_strobe_map_one_r & RESR_WM_SEQ_STROBE_MAP_ONE; // [RQ9]
    end else if (hit_s2) begin
      rd_mux = seq_strobe_map_two_r & RESR_WM_SEQ_STROBE_MAP_TWO; // [RQ11]
    end else begin
      rd_mux = 8'h00;
    end
  end

  // ==========================================================
  // Register storage
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      enable_r <= RESR_RST_ENABLE; // [RQ1]
      uvlo_r <= RESR_RST_UVLO; // [RQ7]
      seq_strobe_map_one_r <= RESR_RST_SEQ_STROBE_MAP_ONE;
      seq_strobe_map_two_r <= RESR_RST_SEQ_STROBE_MAP_TWO;
    end else if (wr_ok) begin
      if (hit_en) begin
        enable_r <= req_in.wdata & RESR_WM_ENABLE; // [RQ1]
      end
      if (hit_uv) begin
        uvlo_r <= req_in.wdata & RESR_WM_UVLO; // [RQ7]
      end
      if (hit_s1) begin
        seq_strobe_map_one_r <= req_in.wdata & RESR_WM_SEQ_STROBE_MAP_ONE; // [RQ9]
      end
      if (hit_s2) begin
        seq_strobe_map_two_r <= req_in.wdata & RESR_WM_SEQ_STROBE_MAP_TWO; // [RQ11]
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      rdata_r <= 8'h00;
      rd_err_r <= 1'b0;
      refused_r <= 1'b0;
    end else begin
      rdata_r <= req_in.rd ? rd_mux : rdata_r;
      rd_err_r <= req_in.rd & ~hit_any;
      refused_r <= req_in.wr & (~unlock_ok_in | ~hit_any); // [RQ6]
    end
  end

  // ==========================================================
  // Rail enables
  // The pin is sampled combinationally so a falling pin drops the switch and buck rails at once
  assign switch_one_on_out = enable_r[RESR_B_SW1] & power_enable_pin_in; // [RQ2]
  assign switch_two_on_out = enable_r[RESR_B_SW2] & power_enable_pin_in; // [RQ3]
  assign buck_one_on_out = enable_r[RESR_B_BK1] & power_enable_pin_in; // [RQ4]
  assign buck_two_on_out = enable_r[RESR_B_BK2] & power_enable_pin_in; // [RQ4]
  assign buck_three_on_out = enable_r[RESR_B_BK3] & power_enable_pin_in; // [RQ4]
  assign linreg_one_on_out = enable_r[RESR_B_LR1]; // [RQ5]
  assign linreg_two_on_out = enable_r[RESR_B_LR2]; // [RQ5]
  assign lockout_threshold_out = resr_uvlo_t'(uvlo_r[1:0]); // [RQ8]
  assign buck_one_slot_out = dec3(seq_strobe_map_one_r[6:4]); // [RQ9]
  assign buck_two_slot_out = dec3(seq_strobe_map_one_r[2:0]); // [RQ9]
  assign buck_three_slot_out = dec3(seq_strobe_map_two_r[6:4]); // [RQ11]
  assign linreg_one_slot_out = dec4(seq_strobe_map_two_r[3:0]); // [RQ11]
  assign rdata_out = rdata_r;
  assign rd_err_out = rd_err_r;
  assign wr_refused_out = refused_r;

  // ==========================================================
  // Checks
  sequence s_locked_wr;
    req_in.wr && !unlock_ok_in && hit_en;
  endsequence
  sequence s_enable_held;
    enable_r == $past(enable_r);
  endsequence
  sequence s_good_wr_uv;
    req_in.wr && unlock_ok_in && hit_uv;
  endsequence
  sequence s_good_wr_s1;
    req_in.wr && unlock_ok_in && hit_s1;
  endsequence
  sequence s_good_wr_s2;
    req_in.wr && unlock_ok_in && hit_s2;
  endsequence

  enable_reset_a: assert property (@(posedge clk_sys_in) // [RQ1]
    sys_rst_in |=> enable_r == RESR_RST_ENABLE && uvlo_r == RESR_RST_UVLO)
    else $error("reset values wrong");
  map_reset_a: assert property (@(posedge clk_sys_in) // [RQ9]
    sys_rst_in
    |=> seq_strobe_map_one_r == RESR_RST_SEQ_STROBE_MAP_ONE && seq_strobe_map_two_r == RESR_RST_SEQ_STROBE_MAP_TWO)
    else $error("map reset values wrong");
  enable_rsv_a: assert property (@(posedge clk_sys_in) // [RQ1]
    disable iff (sys_rst_in) req_in.wr && unlock_ok_in && hit_en
    |=> enable_r == ($past(req_in.wdata) & RESR_WM_ENABLE))
    else $error("enable write wrong");
  enable_top_a: assert property (@(posedge clk_sys_in) // [RQ1]
    disable iff (sys_rst_in)
    !enable_r[7])
    else $error("enable reserved bit set");
  enable_read_a: assert property (@(posedge clk_sys_in) // [RQ1]
    disable iff (sys_rst_in) req_in.rd && hit_en
    |=> !rdata_out[7] && rdata_out[6:0] == $past(enable_r[6:0]))
    else $error("enable read wrong");
  rdata_hold_a: assert property (@(posedge clk_sys_in) // [RQ1]
    disable iff (sys_rst_in) !req_in.rd
    |=> $stable(rdata_out))
    else $error("read data moved without a read");
  unmapped_read_a: assert property (@(posedge clk_sys_in) // [RQ1]
    disable iff (sys_rst_in) req_in.rd && !hit_any
    |=> rd_err_out && rdata_out == 8'h00)
    else $error("unmapped read not flagged");
  switch_one_a: assert property (@(posedge clk_sys_in) // [RQ2]
    disable iff (sys_rst_in)
    switch_one_on_out == (enable_r[RESR_B_SW1] && power_enable_pin_in))
    else $error("switch one mismatch");
  switch_gate_a: assert property (@(posedge clk_sys_in) // [RQ2]
    disable iff (sys_rst_in) !power_enable_pin_in
    |-> !switch_one_on_out && !switch_two_on_out)
    else $error("switch on without pin");
  buck_gate_a: assert property (@(posedge clk_sys_in) // [RQ4]
    disable iff (sys_rst_in)
    buck_one_on_out == (enable_r[RESR_B_BK1] && power_enable_pin_in))
    else $error("buck one mismatch");
  buck_two_a: assert property (@(posedge clk_sys_in) // [RQ4]
    disable iff (sys_rst_in)
    buck_two_on_out == (enable_r[RESR_B_BK2] && power_enable_pin_in))
    else $error("buck two mismatch");
  buck_three_a: assert property (@(posedge clk_sys_in) // [RQ4]
    disable iff (sys_rst_in)
    buck_three_on_out == (enable_r[RESR_B_BK3] && power_enable_pin_in))
    else $error("buck three mismatch");
  switch_two_a: assert property (@(posedge clk_sys_in) // [RQ3]
    disable iff (sys_rst_in)
    switch_two_on_out == (enable_r[RESR_B_SW2] && power_enable_pin_in))
    else $error("switch two mismatch");
  linreg_two_a: assert property (@(posedge clk_sys_in) // [RQ5]
    disable iff (sys_rst_in) req_in.wr && unlock_ok_in && hit_en
    |=> linreg_two_on_out == $past(req_in.wdata[RESR_B_LR2]))
    else $error("linreg two mismatch");
  linreg_direct_a: assert property (@(posedge clk_sys_in) // [RQ5]
    disable iff (sys_rst_in) req_in.wr && unlock_ok_in && hit_en
    |=> linreg_one_on_out == $past(req_in.wdata[1]))
    else $error("linreg one mismatch");
  locked_write_a: assert property (@(posedge clk_sys_in) // [RQ6]
    disable iff (sys_rst_in) s_locked_wr |=> s_enable_held ##0 wr_refused_out)
    else $error("locked write took effect");
  locked_uvlo_a: assert property (@(posedge clk_sys_in) // [RQ6]
    disable iff (sys_rst_in) req_in.wr && !unlock_ok_in && hit_uv
    |=> uvlo_r == $past(uvlo_r) && wr_refused_out)
    else $error("locked uvlo write took effect");
  locked_maps_a: assert property (@(posedge clk_sys_in) // [RQ6]
    disable iff (sys_rst_in) req_in.wr && !unlock_ok_in
    |=> seq_strobe_map_one_r == $past(seq_strobe_map_one_r) && seq_strobe_map_two_r == $past(seq_strobe_map_two_r))
    else $error("locked map write took effect");
  write_taken_a: assert property (@(posedge clk_sys_in) // [RQ6]
    disable iff (sys_rst_in) req_in.wr && unlock_ok_in && hit_any
    |=> !wr_refused_out)
    else $error("good write refused");
  uvlo_write_a: assert property (@(posedge clk_sys_in) // [RQ7]
    disable iff (sys_rst_in) s_good_wr_uv
    |=> uvlo_r == ($past(req_in.wdata) & RESR_WM_UVLO))
    else $error("uvlo write wrong");
  uvlo_rsv_a: assert property (@(posedge clk_sys_in) // [RQ7]
    disable iff (sys_rst_in)
    uvlo_r[7:3] == 5'h00)
    else $error("uvlo reserved bits stored");
  uvlo_read_a: assert property (@(posedge clk_sys_in) // [RQ7]
    disable iff (sys_rst_in) req_in.rd && hit_uv |=> rdata_out[7:3] == 5'h00)
    else $error("uvlo reserved bits set");
  uvlo_field_a: assert property (@(posedge clk_sys_in) // [RQ8]
    disable iff (sys_rst_in) lockout_threshold_out == uvlo_r[1:0])
    else $error("threshold mismatch");
  lr1_slot_a: assert property (@(posedge clk_sys_in) // [RQ12]
    disable iff (sys_rst_in) seq_strobe_map_two_r[3:0] == RESR_L_NOSEQ_B
    |-> linreg_one_slot_out.strobe == 4'h0)
    else $error("code 9 sequenced");
  lr1_s15_a: assert property (@(posedge clk_sys_in) // [RQ12]
    disable iff (sys_rst_in) seq_strobe_map_two_r[3:0] == RESR_L_S15
    |-> linreg_one_slot_out.strobe == 4'hF && linreg_one_slot_out.with_sys)
    else $error("code 15 wrong");
  lr1_s14_a: assert property (@(posedge clk_sys_in) // [RQ12]
    disable iff (sys_rst_in) seq_strobe_map_two_r[3:0] == RESR_L_S14
    |-> linreg_one_slot_out.strobe == 4'hE && !linreg_one_slot_out.with_sys)
    else $error("code 14 wrong");
  lr1_rsv_a: assert property (@(posedge clk_sys_in) // [RQ12]
    disable iff (sys_rst_in)
    seq_strobe_map_two_r[3:0] >= RESR_L_RSV_LO && seq_strobe_map_two_r[3:0] <= RESR_L_RSV_HI
    |-> linreg_one_slot_out.reserved && linreg_one_slot_out.strobe == 4'h0)
    else $error("reserved code not flagged");
  seq_strobe_map_one_write_a: assert property (@(posedge clk_sys_in) // [RQ9]
    disable iff (sys_rst_in) s_good_wr_s1
    |=> seq_strobe_map_one_r == ($past(req_in.wdata) & RESR_WM_SEQ_STROBE_MAP_ONE))
    else $error("map one write wrong");
  seq_strobe_map_one_rsv_a: assert property (@(posedge clk_sys_in) // [RQ9]
    disable iff (sys_rst_in)
    !seq_strobe_map_one_r[7] && !seq_strobe_map_one_r[3])
    else $error("map one reserved bits stored");
  seq_strobe_map_two_write_a: assert property (@(posedge clk_sys_in) // [RQ11]
    disable iff (sys_rst_in) s_good_wr_s2
    |=> seq_strobe_map_two_r == ($past(req_in.wdata) & RESR_WM_SEQ_STROBE_MAP_TWO))
    else $error("map two write wrong");
  zero_slot_a: assert property (@(posedge clk_sys_in) // [RQ10]
    disable iff (sys_rst_in) seq_strobe_map_one_r[6:4] == 3'h0
    |-> buck_one_slot_out == '0)
    else $error("code zero sequenced");
  buck_slot_a: assert property (@(posedge clk_sys_in) // [RQ13]
    disable iff (sys_rst_in) buck_one_slot_out.strobe == {1'b0, seq_strobe_map_one_r[6:4]})
    else $error("buck slot mismatch");
  buck_two_slot_a: assert property (@(posedge clk_sys_in) // [RQ13]
    disable iff (sys_rst_in)
    buck_two_slot_out.strobe == {1'b0, seq_strobe_map_one_r[2:0]})
    else $error("buck two slot mismatch");
  buck_three_slot_a: assert property (@(posedge clk_sys_in) // [RQ11]
    disable iff (sys_rst_in)
    buck_three_slot_out.strobe == {1'b0, seq_strobe_map_two_r[6:4]})
    else $error("buck three slot mismatch");
endmodule : resr_regs
`default_nettype wire

// ==== resr_regs_tb.sv ====
// Self-checking testbench for the rail enable and strobe map registers
`timescale 1ns/1ps
`default_nettype none
module resr_regs_tb;
  import resr_pkg::*;
  logic clk_sys_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic pin = 1'b0;
  resr_req_t req;
  logic unlock, rd_err, wr_ref, flag;
  logic [7:0] rdata, got, v;
  logic [6:0] rails;
  resr_uvlo_t thr;
  resr_slot_t s_b1, s_b2, s_b3, s_l1;
  logic [3:0] e4;
  int err_total = 0;
  int n_tests = 0;
  int cyc = 0;
  // ==========================================================
  // Clock, host and design
  always #12.5 clk_sys_in = ~clk_sys_in;
  resr_host host (.clk_sys_in(clk_sys_in), .req_out(req),
    .unlock_ok_out(unlock));
  resr_regs dut (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
    .req_in(req), .unlock_ok_in(unlock), .power_enable_pin_in(pin),
    .rdata_out(rdata), .rd_err_out(rd_err), .wr_refused_out(wr_ref),
    .switch_one_on_out(rails[6]), .switch_two_on_out(rails[5]),
    .buck_one_on_out(rails[4]), .buck_two_on_out(rails[3]),
    .buck_three_on_out(rails[2]), .linreg_one_on_out(rails[1]),
    .linreg_two_on_out(rails[0]), .lockout_threshold_out(thr),
    .buck_one_slot_out(s_b1), .buck_two_slot_out(s_b2),
    .buck_three_slot_out(s_b3), .linreg_one_slot_out(s_l1));
  // ==========================================================
  // Shared tasks
  task automatic chk(input string nm, input logic [7:0] seen,
                     input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d,
                    input logic u);
    host.op(1'b1, 1'b0, a, d, u);
    host.idle();
    flag = wr_ref;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    host.op(1'b0, 1'b1, a, 8'h00, 1'b0);
    host.idle();
    got = rdata;
    flag = rd_err;
  endtask : rd
  task automatic stop_test();
    if (err_total == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : stop_test
  // Generous ceiling; the sequence needs well under 500 cycles
  always @(posedge clk_sys_in) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_total++;
      stop_test();
    end
  end
  // ==========================================================
  // Test sequence
  initial begin
    repeat (5) @(posedge clk_sys_in);
    #1;
    sys_rst_in = 1'b0;
    rd(RESR_OFS_ENABLE);
    chk("enable reset", got, 8'h00);
    rd(RESR_OFS_UVLO);
    chk("uvlo reset", got, 8'h03);
    chk("threshold reset", {6'h00, thr}, 8'h03);
    // Walk one bit with the pin low, then high; bit 7 alone writes nothing
    for (int i = 0; i < 16; i++) begin
      pin = i[3];
      v = 8'h01 << i[2:0];
      wr(RESR_OFS_ENABLE, v | 8'h80, 1'b1);
      chk("write accepted", {7'h00, flag}, 8'h00);
      rd(RESR_OFS_ENABLE);
      chk("mapped read", {7'h00, flag}, 8'h00);
      chk("enable readback", got, v & 8'h7F);
      chk("rails", {1'b0, rails}, {1'b0, v[6:2] & {5{pin}}, v[1:0]});
    end
    wr(RESR_OFS_ENABLE, 8'h15, 1'b1);
    wr(RESR_OFS_ENABLE, 8'h6A, 1'b0);
    chk("locked write refused", {7'h00, flag}, 8'h01);
    rd(RESR_OFS_ENABLE);
    chk("locked write kept", got, 8'h15);
    for (int i = 0; i < 4; i++) begin
      wr(RESR_OFS_UVLO, 8'hFC | i[7:0], 1'b1);
      rd(RESR_OFS_UVLO);
      chk("uvlo readback", got, 8'h04 | i[7:0]);
      chk("threshold", {6'h00, thr}, i[7:0]);
    end
    for (int c = 0; c < 8; c++) begin
      wr(RESR_OFS_SEQ_STROBE_MAP_ONE, {1'b1, c[2:0], 1'b1, ~c[2:0]}, 1'b1);
      rd(RESR_OFS_SEQ_STROBE_MAP_ONE);
      chk("map one", got, {1'b0, c[2:0], 1'b0, ~c[2:0]});
      chk("buck one slot", {2'b00, s_b1}, {3'b000, c[2:0], 2'b00});
      chk("buck two slot", {2'b00, s_b2}, {3'b000, ~c[2:0], 2'b00});
    end
    for (int c = 0; c < 16; c++) begin
      wr(RESR_OFS_SEQ_STROBE_MAP_TWO, {1'b1, c[2:0], c[3:0]}, 1'b1);
      rd(RESR_OFS_SEQ_STROBE_MAP_TWO);
      chk("map two", got, {1'b0, c[2:0], c[3:0]});
      chk("buck three slot", {2'b00, s_b3}, {3'b000, c[2:0], 2'b00});
      e4 = (c < 8 || c > 13) ? c[3:0] : 4'h0;
      chk("linreg one slot", {2'b00, s_l1},
          {2'b00, e4, c == 15, c > 9 && c < 14});
    end
    rd(8'h17);
    chk("unmapped read", {got[6:0], flag}, 8'h01);
    wr(8'h17, 8'hFF, 1'b1);
    chk("unmapped write", {7'h00, flag}, 8'h01);
    // Mid-run reset must bring the defaults back
    @(posedge clk_sys_in);
    #1;
    sys_rst_in = 1'b1;
    repeat (2) @(posedge clk_sys_in);
    #1;
    sys_rst_in = 1'b0;
    rd(RESR_OFS_ENABLE);
    chk("enable after reset", got, 8'h00);
    rd(RESR_OFS_UVLO);
    chk("uvlo after reset", got, 8'h03);
    chk("rails after reset", {1'b0, rails}, 8'h00);
    stop_test();
  end
endmodule : resr_regs_tb
`default_nettype wire
